// ===== rtl/flash_host_pkg.sv
// Constants and carrier types for the host-side flash reprogramming controller.
// Assumes one 25 MHz clock; the flash device itself is reached only through its pins.
// Notes on behaviour
// - Erase-verify code ends erase, enters verification.
// - Timer-ended erase still needs erase-verify write.
// - Wait 6 us before erase-verify read.
// - Rewrite erase-verify per byte, step addresses.
// - Failed byte: erase again, resume there.
// - Leave erase-verify with another valid command.
// - Program needs setup write then address/data write.
// - One byte per program; verify each immediately.
// - Wait 6 us, read back, compare data.
// - Two all-ones writes reset to read mode.
// - Host init issues double reset write.
// - Erase needs two successive erase-setup writes.
// - Read code then 6 us, free reads.
// - Host erase timer guarantees at least 10 ms.
package flash_host_pkg;
    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam logic [7:0]  CMD_READ    = 8'h00;
    localparam logic [7:0]  CMD_ERASE   = 8'h20;
    localparam logic [7:0]  CMD_EVERIFY = 8'ha0;
    localparam logic [7:0]  CMD_PROG    = 8'h40;
    localparam logic [7:0]  CMD_PVERIFY = 8'hc0;
    localparam logic [7:0]  CMD_RESET   = 8'hff;
    localparam logic [7:0]  ERASED_BYTE = 8'hff;
    localparam int unsigned VERIFY_WAIT_US = 6;
    localparam int unsigned ERASE_MIN_MS   = 10;
    localparam int unsigned PROG_MIN_US    = 10;
    localparam int unsigned VPP_SETTLE_US  = 1;
    localparam int unsigned VERIFY_WAIT_CYC = (CLK_HZ / 1_000_000) * VERIFY_WAIT_US;
    localparam int unsigned ERASE_CYC       = (CLK_HZ / 1_000) * ERASE_MIN_MS;
    localparam int unsigned PROG_CYC        = (CLK_HZ / 1_000_000) * PROG_MIN_US;
    localparam int unsigned VPP_SETTLE_CYC  = (CLK_HZ / 1_000_000) * VPP_SETTLE_US;
    localparam int unsigned STROBE_CYC      = 3;
    localparam int unsigned READ_CYC        = 3;
    localparam int unsigned MAX_TRIES       = 1000;
    localparam int unsigned ADDR_W          = 17;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_ERASE,
        OP_PROGRAM,
        OP_READ
    } op_kind_t;

    typedef struct packed {
        op_kind_t          kind;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } flash_req_t;

    typedef struct packed {
        logic       ok;
        logic       fail;
        logic [7:0] rdata;
    } flash_rsp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        dq_out;
        logic              dq_oe;
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
        logic              vpp_en;
    } flash_pins_t;
endpackage

// ===== rtl/flash_host_ctrl.sv
// Host controller that erases, programs and reads a command-register flash device.
// Assumes the flash data pins come back asynchronously and the supply switch follows vpp_en.
`timescale 1ns/1ns
`default_nettype none
module flash_host_ctrl #(
    parameter int unsigned ERASE_CYCLES = flash_host_pkg::ERASE_CYC,
    parameter logic [flash_host_pkg::ADDR_W-1:0] LAST_ADDR = '1
) (
    // Clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_n_i,
    // Request and answer
    input  wire logic                 req_valid_i,
    input  wire flash_host_pkg::flash_req_t req_i,
    output logic                      req_ready_o,
    output logic                      rsp_valid_o,
    output flash_host_pkg::flash_rsp_t rsp_o,
    // Flash pins
    input  wire logic [7:0]           dq_i,
    output flash_host_pkg::flash_pins_t pins_o
);
    import flash_host_pkg::*;

    typedef enum logic [3:0] {
        S_INIT, S_RST1, S_RST2, S_IDLE, S_SETUP, S_SECOND, S_PULSE,
        S_VERIFY_CMD, S_WAIT, S_SAMPLE, S_READ_CMD, S_DONE
    } state_t;

    typedef enum logic [1:0] { W_IDLE, W_SETUP, W_LOW, W_HIGH } wr_t;

    state_t            st_r, st_nxt;
    wr_t               wr_r;
    logic [23:0]       cnt_r;
    logic [ADDR_W-1:0] addr_r;
    logic [7:0]        data_r, wdata_r, dq_s1_r, dq_s2_r;
    logic [9:0]        tries_r;
    op_kind_t          kind_r;
    flash_rsp_t        rsp_r;
    logic              rsp_v_r, vpp_r, oe_n_r, wr_go, wr_done, cnt_zero, fail_now;
    logic [1:0]        wcnt_r;
    logic [7:0]        wdata_nxt;
    logic [23:0]       pulse_len;
    op_kind_t          cur_kind;
    logic              take, pulse_go, wait_go, read_go, sample_go;
    logic              byte_erased, step_on, done_ok, retry;

    // A write is a setup cycle, then WE low, then data held through the rising edge.
    // The setup cycle lets the device see a settled address when WE falls.
    assign wr_done  = (wr_r == W_HIGH) && (wcnt_r == 2'd0);
    assign cnt_zero = (cnt_r == 24'h0);
    assign fail_now = (tries_r == 10'(MAX_TRIES));
    assign req_ready_o = (st_r == S_IDLE);
    assign rsp_valid_o = rsp_v_r;
    assign rsp_o       = rsp_r;
    assign pins_o = '{addr: addr_r, dq_out: wdata_r, dq_oe: (wr_r != W_IDLE),
                      ce_n: (wr_r == W_IDLE) && oe_n_r, we_n: (wr_r != W_LOW),
                      oe_n: oe_n_r, vpp_en: vpp_r};

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dq_s1_r <= 8'h00;
            dq_s2_r <= 8'h00;
        end else begin
            dq_s1_r <= dq_i;
            dq_s2_r <= dq_s1_r;
        end
    end

    // Write strobe engine.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_r   <= W_IDLE;
            wcnt_r <= 2'd0;
        end else if (wr_go) begin
            wr_r   <= W_SETUP;
        end else if (wr_r == W_SETUP) begin
            wr_r   <= W_LOW;
            wcnt_r <= 2'(STROBE_CYC - 1);
        end else if (wr_r != W_IDLE) begin
            if (wcnt_r != 2'd0) begin
                wcnt_r <= wcnt_r - 2'd1;
            end else if (wr_r == W_LOW) begin
                wr_r   <= W_HIGH;
                wcnt_r <= 2'(STROBE_CYC - 1);
            end else begin
                wr_r <= W_IDLE;
            end
        end
    end

    // A new write may start in the cycle the previous one ends, so busy is no guard here.
    assign wr_go = (st_r != st_nxt) &&
                   (st_nxt inside {S_RST1, S_RST2, S_SETUP, S_SECOND, S_VERIFY_CMD, S_READ_CMD});

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            S_INIT:       if (cnt_zero) st_nxt = S_RST1;
            S_RST1:       if (wr_done) st_nxt = S_RST2;
            S_RST2:       if (wr_done) st_nxt = S_IDLE;
            S_IDLE:       if (req_valid_i && req_i.kind != OP_IDLE)
                              st_nxt = (req_i.kind == OP_READ) ? S_READ_CMD : S_SETUP;
            S_SETUP:      if (wr_done) st_nxt = S_SECOND;
            S_SECOND:     if (wr_done) st_nxt = S_PULSE;
            S_PULSE:      if (cnt_zero) st_nxt = S_VERIFY_CMD;
            S_VERIFY_CMD: if (wr_done) st_nxt = S_WAIT;
            S_WAIT:       if (cnt_zero) st_nxt = S_SAMPLE;
            S_SAMPLE:     if (cnt_zero)
                              st_nxt = step_on ? S_VERIFY_CMD : (retry ? S_SETUP : S_DONE);
            S_READ_CMD:   if (wr_done) st_nxt = S_WAIT;
            S_DONE:       st_nxt = S_IDLE;
            default:      st_nxt = S_INIT;
        endcase
    end

    // Events that load the shared counter, latch a request or latch the answer.
    assign take      = (st_r == S_IDLE) && (st_nxt != S_IDLE);
    assign pulse_go  = (st_r == S_SECOND) && wr_done;
    assign wait_go   = wr_done && ((st_r == S_VERIFY_CMD) || (st_r == S_READ_CMD));
    assign read_go   = (st_r == S_WAIT) && cnt_zero;
    assign sample_go = (st_r == S_SAMPLE) && cnt_zero;
    assign cur_kind  = take ? req_i.kind : kind_r;
    assign pulse_len = (kind_r == OP_ERASE) ? 24'(ERASE_CYCLES) : 24'(PROG_CYC);

    // Verdict on the sampled byte; an erased byte short of the end steps on, not answers.
    assign byte_erased = (dq_s2_r == ERASED_BYTE);
    assign step_on     = (kind_r == OP_ERASE) && byte_erased && (addr_r != LAST_ADDR);
    assign done_ok     = (kind_r == OP_READ) ||
                         ((kind_r == OP_ERASE) && byte_erased && (addr_r == LAST_ADDR)) ||
                         ((kind_r == OP_PROGRAM) && (dq_s2_r == data_r));
    assign retry       = !done_ok && !step_on && !fail_now;

    // Code or byte put on the data pins for the write about to start.
    always_comb begin
        case (st_nxt)
            S_SETUP:      wdata_nxt = (cur_kind == OP_ERASE) ? CMD_ERASE : CMD_PROG;
            S_SECOND:     wdata_nxt = (cur_kind == OP_ERASE) ? CMD_ERASE : data_r;
            S_VERIFY_CMD: wdata_nxt = (cur_kind == OP_ERASE) ? CMD_EVERIFY : CMD_PVERIFY;
            S_READ_CMD:   wdata_nxt = CMD_READ;
            default:      wdata_nxt = CMD_RESET;
        endcase
    end

    // State, supply enable and the one-cycle answer strobe.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r    <= S_INIT;
            vpp_r   <= 1'b1;
            rsp_v_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            vpp_r   <= 1'b1;
            rsp_v_r <= (st_r == S_DONE);
        end
    end

    // One down-counter times supply settling, pulses, verify waits and the read window.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 24'(VPP_SETTLE_CYC);
        end else if (pulse_go) begin
            cnt_r <= pulse_len;
        end else if (wait_go) begin
            cnt_r <= 24'(VERIFY_WAIT_CYC);
        end else if (read_go) begin
            cnt_r <= 24'(READ_CYC);
        end else if (!cnt_zero) begin
            cnt_r <= cnt_r - 24'h1;
        end
    end

    // Data pins change only when a write starts, so they stand through the whole strobe.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wdata_r <= CMD_RESET;
        end else if (wr_go) begin
            wdata_r <= wdata_nxt;
        end
    end

    // Request latch, verify address and pulse count.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            kind_r  <= OP_IDLE;
            addr_r  <= '0;
            data_r  <= 8'h00;
            tries_r <= 10'h0;
        end else if (take) begin
            kind_r  <= req_i.kind;
            addr_r  <= (req_i.kind == OP_ERASE) ? '0 : req_i.addr;
            data_r  <= req_i.data;
            tries_r <= 10'h0;
        end else begin
            if (pulse_go) begin
                tries_r <= tries_r + 10'h1;
            end
            if (sample_go && step_on) begin
                addr_r <= addr_r + 1'b1;
            end
        end
    end

    // Read window and the answer, which holds until the next one is ready.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oe_n_r <= 1'b1;
            rsp_r  <= '0;
        end else if (read_go) begin
            oe_n_r <= 1'b0;
        end else if (sample_go) begin
            oe_n_r <= 1'b1;
            if (done_ok) begin
                rsp_r <= '{ok: 1'b1, fail: 1'b0, rdata: dq_s2_r};
            end else if (fail_now) begin
                rsp_r <= '{ok: 1'b0, fail: 1'b1, rdata: dq_s2_r};
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/flash_host_ctrl_sva.sv
// Checker on the flash host controller ports.
// Assumes a bind onto flash_host_ctrl.
`timescale 1ns/1ns
`default_nettype none
module flash_host_ctrl_chk #(
    parameter int unsigned                       ERASE_CYCLES = 50,
    parameter logic [flash_host_pkg::ADDR_W-1:0] LAST_ADDR    = '1
) (
    // Clock, reset, request and answer
    input wire logic                        core_clk_i,
    input wire logic                        rst_n_i,
    input wire logic                        req_valid_i,
    input wire flash_host_pkg::flash_req_t  req_i,
    input wire logic                        req_ready_o,
    input wire logic                        rsp_valid_o,
    input wire flash_host_pkg::flash_rsp_t  rsp_o,
    // Flash pins
    input wire logic [7:0]                  dq_i,
    input wire flash_host_pkg::flash_pins_t pins_o
);
    import flash_host_pkg::*;
    // Quiet cycles since the last write strobe; a verify read needs 150 of them.
    logic [7:0] hi_cnt_r;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) hi_cnt_r <= 8'h00;
        else if (!pins_o.we_n) hi_cnt_r <= 8'h00;
        else if (hi_cnt_r != 8'hff) hi_cnt_r <= hi_cnt_r + 8'h01;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_we_width: assert property ($fell(pins_o.we_n) |-> !pins_o.we_n [*3] ##1 pins_o.we_n)
        else $error("write strobe width wrong");
    a_addr_held: assert property (!pins_o.we_n && !$past(pins_o.we_n) |-> $stable(pins_o.addr))
        else $error("address moved in a write");
    a_data_after: assert property ($rose(pins_o.we_n) |-> pins_o.dq_oe [*3])
        else $error("data released too early");
    a_data_rise: assert property ($rose(pins_o.we_n) |-> $stable(pins_o.dq_out))
        else $error("data moved at strobe rise");
    a_write_sel: assert property (!pins_o.we_n |-> pins_o.dq_oe && !pins_o.ce_n)
        else $error("write without drive or select");
    a_no_fight: assert property (!pins_o.oe_n |-> !pins_o.dq_oe && pins_o.we_n)
        else $error("read while driving");
    a_supply_on: assert property (!pins_o.we_n |-> pins_o.vpp_en)
        else $error("write with supply off");
    a_verify_wait: assert property ($fell(pins_o.oe_n) |-> hi_cnt_r >= 8'h96)
        else $error("read too soon after write");
    a_one_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("answer longer than a cycle");
    a_take_once: assert property (req_valid_i && req_ready_o && req_i.kind != OP_IDLE |=> !req_ready_o)
        else $error("ready stayed after a take");
    c_ok: cover property (rsp_valid_o && rsp_o.ok);
    c_read: cover property ($fell(pins_o.oe_n));
    c_erase: cover property (req_valid_i && req_ready_o && req_i.kind == OP_ERASE);
endmodule
bind flash_host_ctrl flash_host_ctrl_chk #(.ERASE_CYCLES(ERASE_CYCLES), .LAST_ADDR(LAST_ADDR))
    flash_host_ctrl_chk_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
    .dq_i(dq_i), .pins_o(pins_o));
`default_nettype wire

// ===== tb/flash_dev_model.sv
// Pin-level model of the command-register flash, four bytes deep.
// Assumes the host pin struct; byte 2 survives its first erase.
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model (
    // Pins from the host
    input  wire flash_host_pkg::flash_pins_t pins_i,
    // Data back to the host
    output logic [7:0]                       dq_o
);
    import flash_host_pkg::*;
    logic [7:0] mem [4] = '{4{8'h00}};
    logic [1:0] la = 2'h0;
    logic [1:0] pa = 2'h0;
    int         mode = 0;
    int         erases = 0;
    int         resets = 0;
    // The logic supply is taken as above its threshold for the whole run.
    bit         logic_up = 1'b1;
    wire logic [1:0] ra = (mode == 3) ? la : (mode == 6) ? pa : pins_i.addr[1:0];
    // Nothing pulls the released bus, so it shows the inverse of the byte.
    assign dq_o = (!pins_i.oe_n && !pins_i.ce_n) ? mem[ra] : ~mem[ra];
    always @(negedge pins_i.we_n) la = pins_i.addr[1:0];
    always @(posedge pins_i.we_n or negedge pins_i.vpp_en) begin
        if (!pins_i.vpp_en) begin
            mode = 0;
        end else if (!logic_up) begin
            mode = 0;
        end else if (mode == 4) begin
            mem[la] = mem[la] & pins_i.dq_out;
            pa = la;
            mode = 5;
        end else if (pins_i.dq_out == CMD_RESET) begin
            resets++;
            mode = (mode == 7) ? 0 : 7;
        end else if (pins_i.dq_out == CMD_ERASE && mode == 1) begin
            foreach (mem[i]) mem[i] = (erases == 0 && i == 2) ? 8'h00 : ERASED_BYTE;
            erases++;
            mode = 2;
        end else begin
            case (pins_i.dq_out)
                CMD_ERASE:   mode = 1;
                CMD_EVERIFY: mode = 3;
                CMD_PROG:    mode = 4;
                CMD_PVERIFY: mode = 6;
                default:     mode = 0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_flash_host_ctrl.sv
// Bench for the flash host controller against the pin-level flash model.
// Assumes a short erase count and four addresses.
`timescale 1ns/1ns
`default_nettype none
module tb_flash_host_ctrl;
    import flash_host_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        req_valid_i = 1'b0;
    flash_req_t  req_i = '0;
    logic        req_ready_o;
    logic        rsp_valid_o;
    flash_rsp_t  rsp_o;
    logic [7:0]  dq_i;
    flash_pins_t pins_o;
    int          fail_count = 0;
    int          compares = 0;
    int          cycles = 0;
    always #20 core_clk_i = ~core_clk_i;
    flash_host_ctrl #(.ERASE_CYCLES(50), .LAST_ADDR(17'h00003)) flash_host_ctrl_i (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .dq_i(dq_i),
        .pins_o(pins_o));
    flash_dev_model flash_dev_model_i (.pins_i(pins_o), .dq_o(dq_i));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("fail_count %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // A hang in any wait below is cut by this cycle ceiling.
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic run(input op_kind_t k, input logic [16:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        req_i = '{kind: k, addr: a, data: d};
        req_valid_i = 1'b1;
        while (req_ready_o !== 1'b1) @(negedge core_clk_i);
        @(negedge core_clk_i);
        req_valid_i = 1'b0;
        while (rsp_valid_o !== 1'b1) @(negedge core_clk_i);
        check({7'h00, rsp_o.fail}, 8'h00);
    endtask
    task automatic t_init();
        while (req_ready_o !== 1'b1) @(negedge core_clk_i);
        check(8'(flash_dev_model_i.resets), 8'h02);
        check(8'(flash_dev_model_i.mode), 8'h00);
    endtask
    task automatic t_erase();
        run(OP_ERASE, 17'h00000, 8'h00);
        check({7'h00, rsp_o.ok}, 8'h01);
        check(8'(flash_dev_model_i.erases), 8'h02);
        for (int i = 0; i < 4; i++) check(flash_dev_model_i.mem[i], ERASED_BYTE);
    endtask
    task automatic t_prog();
        run(OP_PROGRAM, 17'h00002, 8'h5a);
        check({7'h00, rsp_o.ok}, 8'h01);
        check(flash_dev_model_i.mem[2], 8'h5a);
        check(8'(flash_dev_model_i.mode), 8'h06);
    endtask
    task automatic t_read();
        run(OP_READ, 17'h00002, 8'h00);
        check(rsp_o.rdata, 8'h5a);
        run(OP_READ, 17'h00001, 8'h00);
        check(rsp_o.rdata, ERASED_BYTE);
    endtask
    initial begin
        repeat (10) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        t_init();
        t_erase();
        t_prog();
        t_read();
        close_out();
    end
endmodule
`default_nettype wire
